// [shared/qvp_pkg.sv]
package qvp_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [6:0] ADDR_STATUS = 7'h6f;
  localparam logic [6:0] ADDR_CONFIG = 7'h70;
  localparam int CFG_W = 22;
  localparam logic [CFG_W-1:0] CFG_RESET = 22'h00_0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // Amplitude and timing
  // ----------------------------------------
  localparam logic [7:0] AMPL_MAX = 8'hff;
  localparam logic [7:0] AMPL_ZERO = 8'h00;
  localparam logic [7:0] GRAD_AUTO_MIN = 8'h01;
  localparam logic [7:0] GRAD_AUTO_MAX = 8'h0f;
  localparam int GRAD_SHIFT = 8;
  localparam int THRESH_SHIFT = 9;
  localparam int STANDSTILL_CYCLES = 2 ** 20;
  localparam logic [10:0] PWM_STEP = 11'h002;
  localparam logic [10:0] PWM_DIV0 = 11'h400;
  localparam logic [10:0] PWM_DIV1 = 11'h2ab;
  localparam logic [10:0] PWM_DIV2 = 11'h200;
  localparam logic [10:0] PWM_DIV3 = 11'h19a;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SS_NORMAL, SS_FREEWHEEL, SS_SHORT_LS, SS_SHORT_HS
  } qvp_still_t;

  typedef struct packed {
    qvp_still_t standstill;
    logic       symmetric;
    logic       autoscale;
    logic [1:0] freq;
    logic [7:0] gradient;
    logic [7:0] offset;
  } qvp_cfg_t;

  typedef struct packed {
    logic       standstill;
    logic       openLoadB;
    logic       openLoadA;
    logic       groundShortB;
    logic       groundShortA;
    logic       overtempWarn;
    logic       overtempShutdown;
    logic       stallFlag;
    logic [2:0] rsvdHi;
    logic [4:0] currentScale;
    logic       fullstep;
    logic [4:0] rsvdLo;
    logic [9:0] loadResult;
  } qvp_status_t;

  function automatic logic [10:0] pwm_div(input logic [1:0] f);
    case (f)
      2'h0: pwm_div = PWM_DIV0;
      2'h1: pwm_div = PWM_DIV1;
      2'h2: pwm_div = PWM_DIV2;
      default: pwm_div = PWM_DIV3;
    endcase
  endfunction : pwm_div
endpackage : qvp_pkg

// [testbench/qvp_host.sv]
`timescale 1ns/1ns
module qvp_host #(
  parameter int SINE_PEAK = 248  // Custom table peak held in 248..252
) (
  // Clock
  input  wire logic        clk,
  // Register port
  output logic             regWrEn,
  output logic             regRdEn,
  output logic [6:0]       regAddr,
  output logic [31:0]      regWrData,
  input  wire logic [31:0] regRdData
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 7'h00;
    regWrData = 32'h0000_0000;
  end

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  task automatic wr(input logic [6:0] a, input logic [31:0] dat);
    logic [31:0] v;
    v = dat;
    // Regulation cannot measure current below this floor
    if (v[18] && v[7:0] <= 8'h40) begin
      v[7:0] = 8'h41;
    end
    @(posedge clk);
    #1;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = v;
    @(posedge clk);
    #1;
    regWrEn = 1'b0;
    // Released bus must not look valid
    regAddr = ~regAddr;
    regWrData = ~regWrData;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [31:0] dat);
    @(posedge clk);
    #1;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge clk);
    #1;
    regRdEn = 1'b0;
    regAddr = ~regAddr;
    dat = regRdData;
  endtask : rd
endmodule : qvp_host

// [testbench/testbench.sv]
`timescale 1ns/1ns
module testbench;
  import qvp_pkg::*;
  logic clk, rst, stepPulse, holdCurrentZero, offTimeZero, driverEnableInputLow;
  logic voltageModeActive, loadSpeedMode, loadSpeedStall, fullstepActive, switchBack;
  logic openLoadA, openLoadB, groundShortAIn, groundShortBIn, overtempWarn;
  logic overtempShutdownIn, halfWave, regWrEn, regRdEn, pwmOut, pwmCycleStart;
  logic driverDisable;
  logic [19:0] measuredStepInterval;
  logic [9:0]  loadMeasurement, coilAOnTime;
  logic [7:0]  currentMeasured, currentTarget, pwmScale;
  logic [4:0]  energyCurrentScale;
  logic [6:0]  regAddr;
  logic [31:0] regWrData, regRdData, d;
  logic [1:0]  standstillMode;
  int          errors, n_checks, n;
  int          divs[4] = '{1024, 683, 512, 410};

  qvp_top #(.STILL_CYCLES(16)) dut_u (
    .clk(clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .stepPulse(stepPulse),
    .measuredStepInterval(measuredStepInterval), .holdCurrentZero(holdCurrentZero),
    .offTimeZero(offTimeZero), .driverEnableInputLow(driverEnableInputLow),
    .voltageModeActive(voltageModeActive), .loadSpeedMode(loadSpeedMode),
    .loadSpeedStall(loadSpeedStall), .fullstepActive(fullstepActive),
    .switchBack(switchBack), .openLoadA(openLoadA), .openLoadB(openLoadB),
    .groundShortAIn(groundShortAIn), .groundShortBIn(groundShortBIn),
    .overtempWarn(overtempWarn), .overtempShutdownIn(overtempShutdownIn),
    .loadMeasurement(loadMeasurement), .coilAOnTime(coilAOnTime),
    .currentMeasured(currentMeasured), .currentTarget(currentTarget), .halfWave(halfWave),
    .energyCurrentScale(energyCurrentScale), .pwmOut(pwmOut), .pwmCycleStart(pwmCycleStart),
    .pwmScale(pwmScale), .standstillMode(standstillMode), .driverDisable(driverDisable));

  qvp_host host_u (
    .clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData));

  always #50 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic st(input logic [31:0] mask, input logic [31:0] exp);
    host_u.rd(ADDR_STATUS, d);
    chk(d & mask, exp, "status");
  endtask : st

  task automatic step;
    stepPulse = 1'b1;
    cyc(1);
    stepPulse = 1'b0;
  endtask : step

  // Bounded search for the next period wrap
  task automatic wrap(output int c);
    c = 0;
    do begin
      cyc(1);
      c++;
    end while (pwmCycleStart !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      errors++;
      $display("CHECK FAILED t=%0t no pwm wrap", $time);
      results();
    end
  endtask : wrap

  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {clk, stepPulse, offTimeZero, driverEnableInputLow, voltageModeActive} = 5'h00;
    {loadSpeedMode, loadSpeedStall, switchBack, groundShortAIn, groundShortBIn} = 5'h00;
    {overtempShutdownIn, halfWave, currentMeasured, currentTarget} = 18'h0_0000;
    {openLoadA, openLoadB, overtempWarn, fullstepActive, holdCurrentZero} = 5'h1f;
    rst = 1'b1;
    errors = 0;
    n_checks = 0;
    measuredStepInterval = 20'h0_0100;
    loadMeasurement = 10'h155;
    coilAOnTime = 10'h2aa;
    energyCurrentScale = 5'h15;
    cyc(2);
    rst = 1'b0;
    host_u.rd(ADDR_CONFIG, d);
    chk(d, 32'h0000_0000, "cfg reset");
    host_u.wr(ADDR_CONFIG, 32'hffff_ffff);
    host_u.rd(ADDR_CONFIG, d);
    chk(d, 32'h003f_ffff, "cfg upper bits");
    host_u.wr(ADDR_STATUS, 32'h0000_0000);
    host_u.rd(ADDR_CONFIG, d);
    chk(d, 32'h003f_ffff, "status write");
    host_u.rd(7'h05, d);
    chk(d, 32'h0000_0000, "unmapped");
    for (int m = 0; m < 4; m++) begin
      host_u.wr(ADDR_CONFIG, 32'(m) << 20);
      chk(32'(standstillMode), 32'(m), "standstill mode");
    end
    holdCurrentZero = 1'b0;
    cyc(1);
    chk(32'(standstillMode), 32'h0000_0000, "hold current nonzero");
    holdCurrentZero = 1'b1;
    $display("registers done");
    step();
    st(32'hffff_ffff, 32'h6415_8155);
    chk(32'(driverDisable), 32'h0000_0000, "open load");
    cyc(20);
    st(32'h8000_03ff, 32'h8000_02aa);
    step();
    loadMeasurement = 10'h000;
    st(32'h0100_0000, 32'h0100_0000);
    voltageModeActive = 1'b1;
    st(32'h0100_0000, 32'h0000_0000);
    loadSpeedMode = 1'b1;
    st(32'h0100_0000, 32'h0100_0000);
    $display("status done");
    {groundShortAIn, groundShortBIn} = 2'h3;
    cyc(1);
    {groundShortAIn, groundShortBIn} = 2'h0;
    cyc(3);
    chk(32'(driverDisable), 32'h0000_0001, "short off");
    st(32'h1800_0000, 32'h1800_0000);
    offTimeZero = 1'b1;
    cyc(1);
    offTimeZero = 1'b0;
    st(32'h1800_0000, 32'h0000_0000);
    chk(32'(driverDisable), 32'h0000_0000, "short cleared");
    overtempShutdownIn = 1'b1;
    cyc(1);
    overtempShutdownIn = 1'b0;
    cyc(3);
    chk(32'(driverDisable), 32'h0000_0001, "overtemp held");
    st(32'h0600_0000, 32'h0600_0000);
    overtempWarn = 1'b0;
    cyc(2);
    chk(32'(driverDisable), 32'h0000_0000, "overtemp cleared");
    $display("protection done");
    host_u.wr(ADDR_CONFIG, 32'h0000_0210);
    cyc(4);
    chk(32'(pwmScale), 32'h0000_0012, "ff amplitude");
    {currentTarget, halfWave} = 9'h1ff;
    cyc(1);
    halfWave = 1'b0;
    cyc(4);
    chk(32'(pwmScale), 32'h0000_0012, "ff ignores current");
    // Two wraps so the threshold is settled before counting
    wrap(n);
    wrap(n);
    n = 0;
    repeat (512) begin
      cyc(1);
      n += int'(pwmOut === 1'b1);
    end
    chk(32'(n), 32'h0000_0023, "pwm duty");
    measuredStepInterval = 20'h0_0001;
    host_u.wr(ADDR_CONFIG, 32'h0000_fff0);
    cyc(4);
    chk(32'(pwmScale), 32'h0000_00ff, "ff saturate");
    measuredStepInterval = 20'h0_0000;
    host_u.wr(ADDR_CONFIG, 32'h0000_0110);
    cyc(4);
    chk(32'(pwmScale), 32'h0000_00ff, "ff zero interval");
    for (int f = 0; f < 4; f++) begin
      host_u.wr(ADDR_CONFIG, (32'(f) << 16) | (32'(f[0]) << 19));
      wrap(n);
      wrap(n);
      wrap(n);
      n = (f == 1 && n == 342) ? 341 : n;
      chk(32'(n), 32'(divs[f] / 2), "pwm period");
    end
    $display("pwm done");
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    {currentTarget, currentMeasured} = 16'h6400;
    host_u.wr(ADDR_CONFIG, 32'h0004_1480);
    repeat (2) begin
      halfWave = 1'b1;
      cyc(1);
      halfWave = 1'b0;
      cyc(2);
    end
    cyc(3);
    chk(32'(pwmScale), 32'h0000_001e, "auto step");
    st(32'h001f_0000, 32'h0003_0000);
    host_u.wr(ADDR_CONFIG, 32'h0004_0f41);
    repeat (4) begin
      halfWave = 1'b1;
      cyc(1);
      halfWave = 1'b0;
      cyc(1);
    end
    switchBack = 1'b1;
    cyc(1);
    switchBack = 1'b0;
    cyc(2);
    chk(32'(pwmScale), 32'h0000_0041, "switch back cap");
    $display("autoscale done");
    results();
  end
endmodule : testbench

// [verilog/qvp_amplitude.sv]
`timescale 1ns/1ns
module qvp_amplitude (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Settings
  input  wire logic        autoscale,
  input  wire logic [7:0]  gradient,
  input  wire logic [7:0]  offset,
  // Motion and feedback
  input  wire logic [19:0] stepInterval,
  input  wire logic        halfWave,
  input  wire logic [7:0]  currentMeasured,
  input  wire logic [7:0]  currentTarget,
  input  wire logic        switchBack,
  // Result
  output logic [7:0]       amplitude
);
  import qvp_pkg::*;

  function automatic logic [7:0] sat_add(input logic [7:0] a,
                                         input logic [19:0] b);
    logic [20:0] s;
    s = {13'h0000, a} + {1'b0, b};
    sat_add = (s > {13'h0000, AMPL_MAX}) ? AMPL_MAX : s[7:0];
  endfunction : sat_add

  logic [7:0]  scale_r, scale_nxt;
  logic [7:0]  amp_r, amp_nxt;
  logic [19:0] velTerm;
  logic [7:0]  lim, up, dn;

  // ----------------------------------------
  // Feed-forward and regulator
  // ----------------------------------------
  // Feed-forward never looks at current inputs
  always_comb begin
    velTerm = (stepInterval == 20'h0_0000) ? 20'h0_00ff :
              (20'(gradient) << GRAD_SHIFT) / stepInterval;
    lim = (gradient < GRAD_AUTO_MIN) ? GRAD_AUTO_MIN :
          (gradient > GRAD_AUTO_MAX) ? GRAD_AUTO_MAX : gradient;
    up = currentTarget - currentMeasured;
    dn = currentMeasured - currentTarget;
    scale_nxt = scale_r;
    if (autoscale && halfWave) begin
      if (currentTarget > currentMeasured) begin
        scale_nxt = sat_add(scale_r, 20'((up < lim) ? up : lim));
      end else begin
        scale_nxt = (scale_r > ((dn < lim) ? dn : lim)) ?
                    8'(scale_r - ((dn < lim) ? dn : lim)) : AMPL_ZERO;
      end
    end
    if (autoscale && switchBack && scale_nxt > offset) begin
      scale_nxt = offset;
    end
    amp_nxt = autoscale ? scale_r : sat_add(offset, velTerm);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      scale_r <= AMPL_ZERO;
      amp_r <= AMPL_ZERO;
    end else begin
      scale_r <= scale_nxt;
      amp_r <= amp_nxt;
    end
  end

  assign amplitude = amp_r;

  property p_ff_sum;
    @(posedge clk) disable iff (rst)
      !autoscale && stepInterval == 20'h0_0000 |=> amp_r == AMPL_MAX;
  endproperty
  a_ff_sum: assert property (p_ff_sum)
    else $error("feed-forward amplitude not saturated");

  property p_step_lim;
    @(posedge clk) disable iff (rst)
      autoscale && halfWave && !switchBack |=>
        (scale_r - $past(scale_r) <= 8'(lim)) ||
        ($past(scale_r) - scale_r <= 8'(lim));
  endproperty
  a_step_lim: assert property (p_step_lim)
    else $error("regulator step exceeds gradient");
endmodule : qvp_amplitude

// [verilog/qvp_pwm_counter.sv]
`timescale 1ns/1ns
module qvp_pwm_counter (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Settings
  input  wire logic [1:0] freq,
  input  wire logic       symmetric,
  input  wire logic [7:0] amplitude,
  // Outputs
  output logic            pwmOut,
  output logic            cycleStart
);
  import qvp_pkg::*;

  logic [10:0] phase_r, phase_nxt;
  logic [10:0] thresh_r, thresh_nxt;
  logic        out_r, out_nxt;
  logic        wrap, midCross;
  logic [10:0] div, half, triVal;
  logic [11:0] sum;
  logic [18:0] prod;

  // ----------------------------------------
  // Phase advances by two per clock
  // ----------------------------------------
  // Odd dividers alternate period lengths, mean stays exact
  always_comb begin
    div = pwm_div(freq);
    half = div >> 1;
    sum = {1'b0, phase_r} + {1'b0, PWM_STEP};
    wrap = sum >= {1'b0, div};
    midCross = (phase_r < half) && (sum[10:0] >= half) && !wrap;
    phase_nxt = wrap ? 11'(sum - {1'b0, div}) : sum[10:0];
    triVal = (phase_r < half) ? phase_r : 11'(div - phase_r);
    prod = 19'(amplitude) * 19'(div);
    thresh_nxt = thresh_r;
    if (wrap || (midCross && !symmetric)) begin
      thresh_nxt = 11'(prod >> THRESH_SHIFT);
    end
    out_nxt = triVal < thresh_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r <= 11'h000;
      thresh_r <= 11'h000;
      out_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      thresh_r <= thresh_nxt;
      out_r <= out_nxt;
    end
  end

  assign pwmOut = out_r;
  assign cycleStart = wrap;

  property p_sym_hold;
    @(posedge clk) disable iff (rst)
      symmetric && !wrap |=> $stable(thresh_r);
  endproperty
  a_sym_hold: assert property (p_sym_hold)
    else $error("threshold changed inside symmetric cycle");
endmodule : qvp_pwm_counter

// [verilog/qvp_top.sv]
`timescale 1ns/1ns
module qvp_top #(
  parameter int STILL_CYCLES = qvp_pkg::STANDSTILL_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [6:0]  regAddr,
  input  wire logic [31:0] regWrData,
  output logic [31:0]      regRdData,
  // Motion
  input  wire logic        stepPulse,
  input  wire logic [19:0] measuredStepInterval,
  input  wire logic        holdCurrentZero,
  input  wire logic        offTimeZero,
  input  wire logic        driverEnableInputLow,
  input  wire logic        voltageModeActive,
  input  wire logic        loadSpeedMode,
  input  wire logic        loadSpeedStall,
  input  wire logic        fullstepActive,
  input  wire logic        switchBack,
  // Analog sense results
  input  wire logic        openLoadA,
  input  wire logic        openLoadB,
  input  wire logic        groundShortAIn,
  input  wire logic        groundShortBIn,
  input  wire logic        overtempWarn,
  input  wire logic        overtempShutdownIn,
  input  wire logic [9:0]  loadMeasurement,
  input  wire logic [9:0]  coilAOnTime,
  input  wire logic [7:0]  currentMeasured,
  input  wire logic [7:0]  currentTarget,
  input  wire logic        halfWave,
  input  wire logic [4:0]  energyCurrentScale,
  // Driver side
  output logic             pwmOut,
  output logic             pwmCycleStart,
  output logic [7:0]       pwmScale,
  output logic [1:0]       standstillMode,
  output logic             driverDisable
);
  import qvp_pkg::*;

  localparam logic [20:0] STILL_LIM = 21'(STILL_CYCLES);

  qvp_cfg_t    cfg_r, cfg_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [20:0] stillCnt_r, stillCnt_nxt;
  logic        gsA_r, gsA_nxt;
  logic        gsB_r, gsB_nxt;
  logic        otLatch_r, otLatch_nxt;
  qvp_status_t status;
  logic        stillFlag;
  logic        clearShort;
  logic        loadValid;
  logic [7:0]  amplitude;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    if (regWrEn && regAddr == ADDR_CONFIG) begin
      cfg_nxt = qvp_cfg_t'(regWrData[CFG_W-1:0]);
    end
    rd_nxt = rd_r;
    if (regRdEn) begin
      case (regAddr)
        ADDR_STATUS: rd_nxt = status;
        ADDR_CONFIG: rd_nxt = {10'h000, cfg_r};
        default:     rd_nxt = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= qvp_cfg_t'(CFG_RESET);
      rd_r <= RD_ZERO;
    end else begin
      cfg_r <= cfg_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign regRdData = rd_r;

  // ----------------------------------------
  // Standstill timer
  // ----------------------------------------
  // Saturates so the flag never drops without a step
  always_comb begin
    stillCnt_nxt = stillCnt_r;
    if (stepPulse) begin
      stillCnt_nxt = 21'h00_0000;
    end else if (stillCnt_r < STILL_LIM) begin
      stillCnt_nxt = 21'(stillCnt_r + 21'h00_0001);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stillCnt_r <= 21'h00_0000;
    end else begin
      stillCnt_r <= stillCnt_nxt;
    end
  end

  assign stillFlag = stillCnt_r >= STILL_LIM;

  // ----------------------------------------
  // Protection latches
  // ----------------------------------------
  // New short wins over a clear in the same cycle
  always_comb begin
    clearShort = offTimeZero || driverEnableInputLow;
    gsA_nxt = groundShortAIn || (gsA_r && !clearShort);
    gsB_nxt = groundShortBIn || (gsB_r && !clearShort);
    otLatch_nxt = overtempShutdownIn ||
                  (otLatch_r && overtempWarn);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gsA_r <= 1'b0;
      gsB_r <= 1'b0;
      otLatch_r <= 1'b0;
    end else begin
      gsA_r <= gsA_nxt;
      gsB_r <= gsB_nxt;
      otLatch_r <= otLatch_nxt;
    end
  end

  // Open load deliberately absent here
  assign driverDisable = gsA_r || gsB_r || otLatch_r ||
                         clearShort;

  // ----------------------------------------
  // Standstill behaviour
  // ----------------------------------------
  assign standstillMode = (stillFlag && holdCurrentZero) ?
                          cfg_r.standstill : SS_NORMAL;

  // ----------------------------------------
  // Amplitude and PWM
  // ----------------------------------------
  qvp_amplitude u_amp (
    .clk             (clk),
    .rst             (rst),
    .autoscale       (cfg_r.autoscale),
    .gradient        (cfg_r.gradient),
    .offset          (cfg_r.offset),
    .stepInterval    (measuredStepInterval),
    .halfWave        (halfWave),
    .currentMeasured (currentMeasured),
    .currentTarget   (currentTarget),
    .switchBack      (switchBack),
    .amplitude       (amplitude)
  );

  qvp_pwm_counter u_pwm (
    .clk        (clk),
    .rst        (rst),
    .freq       (cfg_r.freq),
    .symmetric  (cfg_r.symmetric),
    .amplitude  (amplitude),
    .pwmOut     (pwmOut),
    .cycleStart (pwmCycleStart)
  );

  assign pwmScale = amplitude;

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  // Load result meaningless under voltage PWM unless load-speed mode
  assign loadValid = !voltageModeActive || loadSpeedMode;

  always_comb begin
    status = '0;
    status.standstill = stillFlag;
    status.openLoadB = openLoadB;
    status.openLoadA = openLoadA;
    status.groundShortB = gsB_r;
    status.groundShortA = gsA_r;
    status.overtempWarn = overtempWarn;
    status.overtempShutdown = otLatch_r;
    status.stallFlag = (loadValid && !stillFlag &&
                        loadMeasurement == 10'h000) ||
                       (loadSpeedMode && loadSpeedStall);
    status.currentScale = cfg_r.autoscale ?
                          amplitude[7:3] : energyCurrentScale;
    status.fullstep = fullstepActive;
    status.loadResult = stillFlag ?
                        coilAOnTime : loadMeasurement;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_step_then_quiet;
    stepPulse ##1 !stepPulse [*3];
  endsequence

  property p_still_clear;
    s_step_then_quiet |-> !stillFlag;
  endproperty
  a_still_clear: assert property (p_still_clear)
    else $error("standstill flag set just after a step");

  property p_still_mode;
    !stillFlag |-> standstillMode == SS_NORMAL;
  endproperty
  a_still_mode: assert property (p_still_mode)
    else $error("standstill mode active while moving");

  sequence s_short_seen;
    groundShortAIn ##1 !clearShort;
  endsequence

  property p_short_hold;
    s_short_seen |-> gsA_r && driverDisable;
  endproperty
  a_short_hold: assert property (p_short_hold)
    else $error("ground short not latched or driver not off");

  property p_short_clear;
    gsB_r && clearShort && !groundShortBIn |=> !gsB_r;
  endproperty
  a_short_clear: assert property (p_short_clear)
    else $error("ground short flag not cleared");

  property p_ot_hold;
    otLatch_r && overtempWarn |=> driverDisable;
  endproperty
  a_ot_hold: assert property (p_ot_hold)
    else $error("driver re-enabled during pre-warning");

  property p_open_noact;
    !gsA_r && !gsB_r && !otLatch_r && !clearShort |-> !driverDisable;
  endproperty
  a_open_noact: assert property (p_open_noact)
    else $error("driver disabled without protective cause");

  property p_load_mux;
    regRdEn && regAddr == ADDR_STATUS && stillFlag |=>
      regRdData[9:0] == $past(coilAOnTime);
  endproperty
  a_load_mux: assert property (p_load_mux)
    else $error("standstill read lacks coil A on-time");

  property p_cfg_rsvd;
    regRdEn && regAddr == ADDR_CONFIG |=> regRdData[31:CFG_W] == '0;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd)
    else $error("reserved config bits read nonzero");

  property p_stat_rsvd;
    regRdEn && regAddr == ADDR_STATUS |=>
      regRdData[23:21] == '0 && regRdData[14:10] == '0;
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd)
    else $error("reserved status bits read nonzero");
endmodule : qvp_top
